// ### include/alert_mask_pkg.sv
// Purpose: Shared constants for the alert enable mask block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Printed offsets are register indices; byte address is index times four
`default_nettype none
package alert_mask_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ENABLE_INDEX = 32'h49;
  localparam logic [11:0] ENABLE_ADDR = 12'h124;
  localparam logic [11:0] ACTIVE_ADDR = 12'h128;
  localparam logic [11:0] COMMIT_ADDR = 12'h12c;
  localparam logic [11:0] STATUS_ADDR = 12'h130;
  localparam logic [11:0] COUNT_ADDR = 12'h134;
  // ----------------------------------------------------------------
  // Field layout of the enable word
  // ----------------------------------------------------------------
  localparam int unsigned MASK_WIDTH = 24;
  localparam int unsigned NUM_CHANNELS = 4;
  localparam int unsigned OVERCURRENT_LSB = 20;
  localparam int unsigned UNDERCURRENT_LSB = 16;
  localparam int unsigned OVERVOLTAGE_LSB = 12;
  localparam int unsigned UNDERVOLTAGE_LSB = 8;
  localparam int unsigned OVERPOWER_LSB = 4;
  localparam int unsigned ACCUM_FULL_BIT = 3;
  localparam int unsigned ACCUM_TALLY_BIT = 2;
  localparam int unsigned CONV_DONE_BIT = 1;
  localparam logic [23:0] WRITABLE_MASK = 24'hfffffe;
  localparam logic [23:0] MASK_RESET = 24'h000000;
  // ----------------------------------------------------------------
  // Commit command codes, written to the commit register
  // ----------------------------------------------------------------
  localparam logic [1:0] COMMIT_FULL = 2'h1;
  localparam logic [1:0] COMMIT_KEEP_ACCUM = 2'h2;
  localparam logic [1:0] COMMIT_GLOBAL = 2'h3;
  // ----------------------------------------------------------------
  // Consecutive sample codes
  // ----------------------------------------------------------------
  localparam logic [4:0] SAMPLES_CODE0 = 5'h01;
  localparam logic [4:0] SAMPLES_CODE1 = 5'h04;
  localparam logic [4:0] SAMPLES_CODE2 = 5'h08;
  localparam logic [4:0] SAMPLES_CODE3 = 5'h10;
  localparam logic [4:0] COUNT_RESET = 5'h00;
endpackage
`default_nettype wire

// ### src/sample_qualifier.sv
// Purpose: Counts consecutive over-limit samples for one source
// Assumes: sample_valid pulses once per conversion on sys_clk
// Notes: Fires a one-cycle pulse each time the run reaches the count
`default_nettype none
module sample_qualifier (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic sample_valid,
  input wire logic over_limit,
  input wire logic [1:0] consecutive_sample_count,
  output logic qualified
);
  import alert_mask_pkg::*;
  logic [4:0] run;
  logic [4:0] target;

  // ----------------------------------------------------------------
  // Count decode
  // ----------------------------------------------------------------
  // count code decode
  always_comb begin
    case (consecutive_sample_count)
      2'h0: target = SAMPLES_CODE0;
      2'h1: target = SAMPLES_CODE1;
      2'h2: target = SAMPLES_CODE2;
      default: target = SAMPLES_CODE3;
    endcase
  end

  // Run length; restarts after a fire so a steady fault repeats
  // consecutive run counter
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      run <= COUNT_RESET;
      qualified <= 1'b0;
    end else begin
      qualified <= 1'b0;
      if (sample_valid) begin
        if (!over_limit) begin
          run <= COUNT_RESET;
        end else if (run + 5'h01 >= target) begin
          run <= COUNT_RESET;
          qualified <= 1'b1;
        end else begin
          run <= run + 5'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### src/commit_sync.sv
// Purpose: Three-stage synchroniser for the external commit pin
// Assumes: Pin is asynchronous to sys_clk
// Notes: A change counts once the second and third stages agree
`default_nettype none
module commit_sync (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic pin_in,
  output logic rise
);
  logic s1;
  logic s2;
  logic s3;
  logic level;

  // Stage chain; first stage feeds only the second
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
      rise <= 1'b0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      rise <= 1'b0;
      if (s2 == s3 && s3 != level) begin
        level <= s3;
        rise <= s3;
      end
    end
  end
endmodule
`default_nettype wire

// ### src/alert_enable_mask.sv
// Purpose: Per-channel alert enable mask with commit-to-active copy
// Assumes: APB slave, 125 MHz sys_clk, asynchronous active-high reset
// Notes: Written mask is shadowed; only a commit makes it active
//
// The APB register port was left to the implementer.
`default_nettype none
module alert_enable_mask #(
  parameter int unsigned CHANNELS = alert_mask_pkg::NUM_CHANNELS
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic commit_pin,
  input wire logic sample_valid,
  input wire logic [CHANNELS-1:0] overcurrent,
  input wire logic [CHANNELS-1:0] undercurrent,
  input wire logic [CHANNELS-1:0] overvoltage,
  input wire logic [CHANNELS-1:0] undervoltage,
  input wire logic [CHANNELS-1:0] overpower,
  input wire logic [2*CHANNELS-1:0] overcurrent_samples,
  input wire logic [2*CHANNELS-1:0] undercurrent_samples,
  input wire logic [2*CHANNELS-1:0] overvoltage_samples,
  input wire logic [2*CHANNELS-1:0] undervoltage_samples,
  input wire logic [2*CHANNELS-1:0] overpower_samples,
  input wire logic accum_full,
  input wire logic accum_tally_full,
  input wire logic conversion_done,
  output logic [alert_mask_pkg::MASK_WIDTH-1:0] gated_alert,
  output logic alert_any
);
  import alert_mask_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [MASK_WIDTH-1:0] alert_source_enable;
  logic [MASK_WIDTH-1:0] active_enable;
  logic [MASK_WIDTH-1:0] raw_event;
  logic [MASK_WIDTH-1:0] next_gated;
  logic [5*CHANNELS-1:0] limit_hit;
  logic [5*CHANNELS-1:0] limit_qualified;
  logic [10*CHANNELS-1:0] sample_codes;
  logic [7:0] commit_count;
  logic pin_commit;
  logic bus_commit;
  logic do_commit;
  logic access;
  logic wr;
  logic known_addr;
  logic [31:0] next_rdata;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Single-cycle access phase; pready never stalls
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign known_addr = (paddr == ENABLE_ADDR) || (paddr == ACTIVE_ADDR) ||
                      (paddr == COMMIT_ADDR) || (paddr == STATUS_ADDR) ||
                      (paddr == COUNT_ADDR);
  assign bus_commit = wr && (paddr == COMMIT_ADDR) &&
                      (pwdata[1:0] == COMMIT_FULL || pwdata[1:0] == COMMIT_KEEP_ACCUM ||
                       pwdata[1:0] == COMMIT_GLOBAL);
  assign do_commit = bus_commit | pin_commit;

  // ----------------------------------------------------------------
  // Commit pin synchroniser
  // ----------------------------------------------------------------
  commit_sync u_commit_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin_in(commit_pin),
    .rise(pin_commit)
  );

  // ----------------------------------------------------------------
  // Written copy of the mask
  // ----------------------------------------------------------------
  // written copy reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      alert_source_enable <= MASK_RESET;
    end else if (wr && paddr == ENABLE_ADDR) begin
      alert_source_enable <= pwdata[MASK_WIDTH-1:0] & WRITABLE_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Active copy, loaded only by commit
  // ----------------------------------------------------------------
  // copy written to active
  // activation on commit
  // A write in the same cycle as a commit is not yet seen: it needs the next commit
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      active_enable <= MASK_RESET;
      commit_count <= 8'h00;
    end else if (do_commit) begin
      active_enable <= alert_source_enable;
      commit_count <= commit_count + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Consecutive sample qualification per limit source
  // ----------------------------------------------------------------
  // Order of groups: overpower, undervoltage, overvoltage, undercurrent, overcurrent
  assign limit_hit = {overcurrent, undercurrent, overvoltage, undervoltage, overpower};
  assign sample_codes = {overcurrent_samples, undercurrent_samples, overvoltage_samples,
                         undervoltage_samples, overpower_samples};

  genvar gi;
  generate
    for (gi = 0; gi < 5 * CHANNELS; gi++) begin : g_qual
      sample_qualifier u_qual (
        .sys_clk(sys_clk),
        .reset(reset),
        .sample_valid(sample_valid),
        .over_limit(limit_hit[gi]),
        .consecutive_sample_count(sample_codes[2*gi+1 -: 2]),
        .qualified(limit_qualified[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Event map onto mask layout
  // ----------------------------------------------------------------
  // Channel 1 sits on the high bit of each group, so the vector reverses
  always_comb begin
    raw_event = '0;
    for (int c = 0; c < CHANNELS; c++) begin
      raw_event[OVERCURRENT_LSB + 3 - c] = limit_qualified[4*CHANNELS + c];
      raw_event[UNDERCURRENT_LSB + 3 - c] = limit_qualified[3*CHANNELS + c];
      raw_event[OVERVOLTAGE_LSB + 3 - c] = limit_qualified[2*CHANNELS + c];
      raw_event[UNDERVOLTAGE_LSB + 3 - c] = limit_qualified[CHANNELS + c];
      raw_event[OVERPOWER_LSB + 3 - c] = limit_qualified[c];
    end
    raw_event[ACCUM_FULL_BIT] = accum_full;
    raw_event[ACCUM_TALLY_BIT] = accum_tally_full;
    raw_event[CONV_DONE_BIT] = conversion_done;
  end

  assign next_gated = raw_event & active_enable;

  // Registered so routing never sees a glitch
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      gated_alert <= '0;
      alert_any <= 1'b0;
    end else begin
      gated_alert <= next_gated;
      alert_any <= |next_gated;
    end
  end

  // ----------------------------------------------------------------
  // Read data and response
  // ----------------------------------------------------------------
  // Status shows registered gated_alert: active mask filtered by the events of the previous cycle
  always_comb begin
    next_rdata = 32'h00000000;
    case (paddr)
      ENABLE_ADDR: next_rdata[MASK_WIDTH-1:0] = alert_source_enable;
      ACTIVE_ADDR: next_rdata[MASK_WIDTH-1:0] = active_enable;
      STATUS_ADDR: next_rdata[MASK_WIDTH-1:0] = gated_alert;
      COUNT_ADDR: next_rdata[7:0] = commit_count;
      default: next_rdata = 32'h00000000;
    endcase
  end

  // Answer in the setup cycle so access completes at once
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~known_addr;
      if (psel && !penable && !pwrite) begin
        prdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // bit 0 never held
  AST_BIT0_ZERO: assert property (@(posedge sys_clk) disable iff (reset)
    alert_source_enable[0] == 1'b0 && active_enable[0] == 1'b0)
    else $error("unimplemented bit stored");

  AST_WRITE_HOLD: assert property (@(posedge sys_clk) disable iff (reset)
    (wr && paddr == ENABLE_ADDR && !do_commit) |=> (active_enable == $past(active_enable)))
    else $error("active mask changed without commit");

  AST_NO_COMMIT_HOLD: assert property (@(posedge sys_clk) disable iff (reset)
    !do_commit |=> $stable(active_enable))
    else $error("active mask moved without commit");

  AST_COMMIT_COPY: assert property (@(posedge sys_clk) disable iff (reset)
    do_commit |=> (active_enable == $past(alert_source_enable)))
    else $error("commit did not copy written mask");

  AST_COMMIT_COUNT: assert property (@(posedge sys_clk) disable iff (reset)
    do_commit |=> (commit_count == $past(commit_count) + 8'h01))
    else $error("commit count did not advance");

  AST_COUNT_HOLD: assert property (@(posedge sys_clk) disable iff (reset)
    !do_commit |=> $stable(commit_count))
    else $error("commit count moved without commit");

  AST_GATED: assert property (@(posedge sys_clk) disable iff (reset)
    ((gated_alert & ~$past(active_enable)) == '0))
    else $error("disabled source reached alert");

  AST_STORE_MASKED: assert property (@(posedge sys_clk) disable iff (reset)
    (wr && paddr == ENABLE_ADDR) |=> (alert_source_enable == ($past(pwdata[23:0]) & WRITABLE_MASK)))
    else $error("written mask not stored");

  // Refused writes leave the written copy alone
  AST_UNMAPPED_IGNORED: assert property (@(posedge sys_clk) disable iff (reset)
    (wr && !known_addr) |=> $stable(alert_source_enable))
    else $error("unmapped write changed the mask");

  AST_CONV_DONE: assert property (@(posedge sys_clk) disable iff (reset)
    (conversion_done && active_enable[CONV_DONE_BIT]) |=> gated_alert[CONV_DONE_BIT])
    else $error("conversion done alert missing");

  AST_CONV_BLOCK: assert property (@(posedge sys_clk) disable iff (reset)
    !active_enable[CONV_DONE_BIT] |=> !gated_alert[CONV_DONE_BIT])
    else $error("conversion done alert passed while disabled");

  AST_ACCUM_FULL: assert property (@(posedge sys_clk) disable iff (reset)
    (accum_full && active_enable[ACCUM_FULL_BIT]) |=> gated_alert[ACCUM_FULL_BIT])
    else $error("accumulator full alert missing");

  AST_ACCUM_BLOCK: assert property (@(posedge sys_clk) disable iff (reset)
    !active_enable[ACCUM_FULL_BIT] |=> !gated_alert[ACCUM_FULL_BIT])
    else $error("accumulator full alert passed while disabled");

  AST_TALLY_PASS: assert property (@(posedge sys_clk) disable iff (reset)
    (accum_tally_full && active_enable[ACCUM_TALLY_BIT]) |=> gated_alert[ACCUM_TALLY_BIT])
    else $error("tally alert missing");

  AST_TALLY_BLOCK: assert property (@(posedge sys_clk) disable iff (reset)
    !active_enable[ACCUM_TALLY_BIT] |=> !gated_alert[ACCUM_TALLY_BIT])
    else $error("tally alert passed while disabled");

  // channel 1 overcurrent on bit 23
  AST_OC1_MAP: assert property (@(posedge sys_clk) disable iff (reset)
    (limit_qualified[4*CHANNELS] && active_enable[23]) |=> gated_alert[23])
    else $error("channel 1 overcurrent misrouted");

  // Routing checks per channel; channel 1 sits on the high bit of each group
  for (genvar ci = 0; ci < CHANNELS; ci++) begin : g_route_chk
    AST_OC_ROUTE: assert property (@(posedge sys_clk) disable iff (reset)
      (limit_qualified[4*CHANNELS + ci] && active_enable[OVERCURRENT_LSB + 3 - ci])
      |=> gated_alert[OVERCURRENT_LSB + 3 - ci])
      else $error("overcurrent alert misrouted");

    AST_UC_ROUTE: assert property (@(posedge sys_clk) disable iff (reset)
      (limit_qualified[3*CHANNELS + ci] && active_enable[UNDERCURRENT_LSB + 3 - ci])
      |=> gated_alert[UNDERCURRENT_LSB + 3 - ci])
      else $error("undercurrent alert misrouted");

    AST_OV_ROUTE: assert property (@(posedge sys_clk) disable iff (reset)
      (limit_qualified[2*CHANNELS + ci] && active_enable[OVERVOLTAGE_LSB + 3 - ci])
      |=> gated_alert[OVERVOLTAGE_LSB + 3 - ci])
      else $error("overvoltage alert misrouted");

    AST_UV_ROUTE: assert property (@(posedge sys_clk) disable iff (reset)
      (limit_qualified[CHANNELS + ci] && active_enable[UNDERVOLTAGE_LSB + 3 - ci])
      |=> gated_alert[UNDERVOLTAGE_LSB + 3 - ci])
      else $error("undervoltage alert misrouted");

    AST_OP_ROUTE: assert property (@(posedge sys_clk) disable iff (reset)
      (limit_qualified[ci] && active_enable[OVERPOWER_LSB + 3 - ci])
      |=> gated_alert[OVERPOWER_LSB + 3 - ci])
      else $error("overpower alert misrouted");
  end

  // qualifiers fire only after a sample
  AST_QUAL_SAMPLE: assert property (@(posedge sys_clk) disable iff (reset)
    (|limit_qualified) |-> $past(sample_valid))
    else $error("limit qualified without a sample");

  AST_ANY: assert property (@(posedge sys_clk) disable iff (reset)
    alert_any == (gated_alert != '0))
    else $error("summary alert mismatch");

  // Wait-free slave: ready is a single-cycle pulse
  AST_PREADY_PULSE: assert property (@(posedge sys_clk) disable iff (reset)
    pready |=> !pready)
    else $error("ready held past access phase");

  // An error answer always comes with ready
  AST_ERR_WITH_READY: assert property (@(posedge sys_clk) disable iff (reset)
    pslverr |-> pready)
    else $error("error response without ready");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  COV_COMMIT: cover property (@(posedge sys_clk) disable iff (reset) bus_commit);
  COV_PIN_COMMIT: cover property (@(posedge sys_clk) disable iff (reset) pin_commit);
  COV_ALERT: cover property (@(posedge sys_clk) disable iff (reset) alert_any);
  COV_ERR: cover property (@(posedge sys_clk) disable iff (reset) pslverr && pready);
  COV_RUN16: cover property (@(posedge sys_clk) disable iff (reset)
    limit_qualified[4*CHANNELS] && overcurrent_samples[1:0] == 2'h3);
endmodule
`default_nettype wire

// ### bench/alert_enable_mask_tb.sv
// Purpose: Self-checking bench for the alert enable mask over APB
// Assumes: Wait-free APB slave, event levels held high while sample pulses run
// Notes: Gated outputs are sampled one step after the edge that settles them
`default_nettype none
module alert_enable_mask_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import alert_mask_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic commit_pin = 1'b0;
  logic sample_valid = 1'b0;
  logic [3:0] overcurrent = 4'h0;
  logic [3:0] undercurrent = 4'h0;
  logic [3:0] overvoltage = 4'h0;
  logic [3:0] undervoltage = 4'h0;
  logic [3:0] overpower = 4'h0;
  logic [7:0] overcurrent_samples = 8'h00;
  logic [7:0] undercurrent_samples = 8'h00;
  logic [7:0] overvoltage_samples = 8'h00;
  logic [7:0] undervoltage_samples = 8'h00;
  logic [7:0] overpower_samples = 8'h00;
  logic accum_full = 1'b0;
  logic accum_tally_full = 1'b0;
  logic conversion_done = 1'b0;
  logic [23:0] gated_alert;
  logic alert_any;
  logic [31:0] rd;
  logic rerr;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [1:0] codes [3] = '{COMMIT_FULL, COMMIT_KEEP_ACCUM, COMMIT_GLOBAL};
  int runs [4] = '{1, 4, 8, 16};

  alert_enable_mask #(.CHANNELS(4)) i_alert_enable_mask (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .commit_pin(commit_pin), .sample_valid(sample_valid), .overcurrent(overcurrent),
    .undercurrent(undercurrent), .overvoltage(overvoltage), .undervoltage(undervoltage),
    .overpower(overpower), .overcurrent_samples(overcurrent_samples),
    .undercurrent_samples(undercurrent_samples), .overvoltage_samples(overvoltage_samples),
    .undervoltage_samples(undervoltage_samples), .overpower_samples(overpower_samples),
    .accum_full(accum_full), .accum_tally_full(accum_tally_full),
    .conversion_done(conversion_done), .gated_alert(gated_alert), .alert_any(alert_any)
  );

  // Free-running 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // APB master: request held until pready is sampled high
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) check("pready", {31'h0, pready}, 32'h1);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, rerr);
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd, rerr);
    check(nm, rd, exp);
  endtask

  // One sample pulse, then look where a run of one shows up
  task automatic fire();
    @(posedge sys_clk);
    sample_valid <= 1'b1;
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic chk_gate(input logic [23:0] exp);
    check("gated_alert", {8'h0, gated_alert}, {8'h0, exp});
    check("alert_any", {31'h0, alert_any}, {31'h0, |exp});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    rd_chk("enable_reset", ENABLE_ADDR, 32'h0);
    rd_chk("active_reset", ACTIVE_ADDR, 32'h0);
    // Every source asserted; only the active mask may let it through
    @(posedge sys_clk);
    {overcurrent, undercurrent, overvoltage, undervoltage, overpower} <= '1;
    {accum_full, accum_tally_full, conversion_done} <= 3'b111;
    wr(ENABLE_ADDR, 32'hffffffff);
    rd_chk("enable_rb", ENABLE_ADDR, 32'h00fffffe);
    rd_chk("active_pre", ACTIVE_ADDR, 32'h0);
    fire();
    chk_gate(24'h000000);
    wr(COMMIT_ADDR, 32'h0);
    rd_chk("active_code0", ACTIVE_ADDR, 32'h0);
    wr(COMMIT_ADDR, {30'h0, COMMIT_FULL});
    rd_chk("active_all", ACTIVE_ADDR, 32'h00fffffe);
    fire();
    chk_gate(24'hfffffe);
    // Walk one enable at a time, cycling through the commit variants
    for (int b = 1; b < 24; b++) begin
      wr(ENABLE_ADDR, 32'h1 << b);
      wr(COMMIT_ADDR, {30'h0, codes[b % 3]});
      fire();
      chk_gate(24'h1 << b);
    end
    // Run length per sample code on channel 1 overcurrent
    wr(ENABLE_ADDR, 32'h00800000);
    wr(COMMIT_ADDR, {30'h0, COMMIT_FULL});
    for (int c = 0; c < 4; c++) begin
      // alerts off while the sample count changes
      wr(ENABLE_ADDR, 32'h0);
      wr(COMMIT_ADDR, {30'h0, COMMIT_FULL});
      @(posedge sys_clk);
      overcurrent_samples <= {6'h0, c[1:0]};
      wr(ENABLE_ADDR, 32'h00800000);
      wr(COMMIT_ADDR, {30'h0, COMMIT_FULL});
      for (int k = 1; k <= runs[c]; k++) begin
        fire();
        chk_gate((k == runs[c]) ? 24'h800000 : 24'h000000);
      end
    end
    // Commit from the pin, held long enough for the synchroniser
    wr(ENABLE_ADDR, 32'h00000002);
    @(posedge sys_clk);
    commit_pin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    commit_pin <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rd_chk("active_pin", ACTIVE_ADDR, 32'h00000002);
    // Conversion done is still held high, so only bit 1 shows
    rd_chk("status_pin", STATUS_ADDR, 32'h00000002);
    // Unmapped address is refused on both directions
    apb(1'b1, 12'h200, 32'hffffffff, rd, rerr);
    check("wr_slverr", {31'h0, rerr}, 32'h1);
    apb(1'b0, 12'h200, 32'h0, rd, rerr);
    check("rd_slverr", {31'h0, rerr}, 32'h1);
    check("rd_unmapped", rd, 32'h0);
    // Second reset in mid-run clears both copies
    wr(ENABLE_ADDR, 32'h00fffffe);
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rd_chk("enable_rst2", ENABLE_ADDR, 32'h0);
    rd_chk("active_rst2", ACTIVE_ADDR, 32'h0);
    rd_chk("count_rst2", COUNT_ADDR, 32'h0);
    wr(COMMIT_ADDR, {30'h0, COMMIT_KEEP_ACCUM});
    rd_chk("count_one", COUNT_ADDR, 32'h1);
    fire();
    chk_gate(24'h000000);
    report_and_stop();
  end
endmodule
`default_nettype wire
